// ===== hw/cog_sync.sv
`timescale 1ns/100ps
module cog_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Level in and out
  input wire logic d_in,
  output logic q_out
);
  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  always_comb begin
    meta_next = d_in;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;
endmodule : cog_sync

// ===== hw/cog_top.sv
`timescale 1ns/100ps
module cog_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Host register port
  input cog_pkg::cog_req_t host_req,
  output logic [7:0] host_rdata,
  // Pins and per-channel interrupt sources
  input wire logic master_tx_en_pin,
  input cog_pkg::cog_chan_t chan,
  // Line control and interrupt pin
  output logic [5:0] transmit_driver_enable,
  output logic [5:0] tx_line_oe_n,
  output logic [5:0] rx_line_oe_n,
  output logic [5:0] receiver_enable_bit,
  output logic irq_out_n
);
  import cog_pkg::*;

  logic [5:0] irq_master_enable_low_reg;
  logic [5:0] irq_master_enable_low_next;
  logic [5:0] tx_on_high_reg;
  logic [5:0] tx_on_high_next;
  logic [5:0] rx_on_high_reg;
  logic [5:0] rx_on_high_next;
  logic [5:0] irq_status_reg;
  logic [5:0] irq_status_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [5:0] drv_reg;
  logic [5:0] drv_next;
  logic [5:0] rcv_reg;
  logic [5:0] rcv_next;
  logic [5:0] txoe_reg;
  logic [5:0] txoe_next;
  logic [5:0] rxoe_reg;
  logic [5:0] rxoe_next;
  logic irq_n_reg;
  logic irq_n_next;
  logic master_tx_sync;
  // Assertion helpers only
  logic [5:0] set_mask;
  logic [5:0] keep_mask;
  logic [5:0] clr_mask;
  logic [5:0] wr_bits;

  // Pin comes from outside the clock domain
  cog_sync u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d_in(master_tx_en_pin),
    .q_out(master_tx_sync)
  );

  function automatic logic [7:0] cog_pad(input logic [5:0] v);
    cog_pad = {2'b00, v};
  endfunction : cog_pad

  always_comb begin
    irq_master_enable_low_next = irq_master_enable_low_reg;
    tx_on_high_next = tx_on_high_reg;
    rx_on_high_next = rx_on_high_reg;
    if (host_req.wr) begin
      case (host_req.addr)
        COG_OFS_IRQ_EN: irq_master_enable_low_next = host_req.wdata[5:0];
        COG_OFS_TX_ON: tx_on_high_next = host_req.wdata[5:0];
        COG_OFS_RX_ON: rx_on_high_next = host_req.wdata[5:0];
        default: ;
      endcase
    end
    // Set wins over the read-clear in the same cycle
    irq_status_next = (irq_status_reg & ~chan.src_read) | (chan.irq_req & chan.src_en);
    rdata_next = rdata_reg;
    if (host_req.rd) begin
      case (host_req.addr)
        COG_OFS_IRQ_EN: rdata_next = cog_pad(irq_master_enable_low_reg);
        COG_OFS_IRQ_ST: rdata_next = cog_pad(irq_status_reg);
        COG_OFS_TX_ON: rdata_next = cog_pad(tx_on_high_reg);
        COG_OFS_RX_ON: rdata_next = cog_pad(rx_on_high_reg);
        default: rdata_next = COG_RD_UNMAPPED;
      endcase
    end
    drv_next = tx_on_high_reg & {6{master_tx_sync}};
    rcv_next = rx_on_high_reg;
    // Own flops so the pins never pass through an inverter
    txoe_next = ~drv_next;
    rxoe_next = ~rcv_next;
    irq_n_next = ~(|(irq_status_reg & irq_master_enable_low_reg));
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_master_enable_low_reg <= COG_RST_IRQ_EN;
      tx_on_high_reg <= COG_RST_TX_ON;
      rx_on_high_reg <= COG_RST_RX_ON;
      irq_status_reg <= 6'h00;
      rdata_reg <= 8'h00;
      drv_reg <= 6'h00;
      rcv_reg <= 6'h00;
      txoe_reg <= 6'h3F;
      rxoe_reg <= 6'h3F;
      irq_n_reg <= 1'b1;
    end else begin
      irq_master_enable_low_reg <= irq_master_enable_low_next;
      tx_on_high_reg <= tx_on_high_next;
      rx_on_high_reg <= rx_on_high_next;
      irq_status_reg <= irq_status_next;
      rdata_reg <= rdata_next;
      drv_reg <= drv_next;
      rcv_reg <= rcv_next;
      txoe_reg <= txoe_next;
      rxoe_reg <= rxoe_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign host_rdata = rdata_reg;
  assign transmit_driver_enable = drv_reg;
  // Low enable drives; high means both line pins float
  assign tx_line_oe_n = txoe_reg;
  assign rx_line_oe_n = rxoe_reg;
  assign receiver_enable_bit = rcv_reg;
  assign irq_out_n = irq_n_reg;

  assign set_mask = chan.irq_req & chan.src_en;
  assign keep_mask = irq_status_reg & ~chan.src_read;
  assign clr_mask = irq_status_reg & chan.src_read & ~set_mask;
  assign wr_bits = host_req.wdata[5:0];

  sequence s_irq_raise;
    ##1 (|(irq_status_reg & irq_master_enable_low_reg));
  endsequence

  property p_tx_gate;
    @(posedge clk_sys) disable iff (!arst_n)
      (!master_tx_sync) |=> (transmit_driver_enable == 6'h00);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("driver on without master pin");

  property p_tx_on;
    @(posedge clk_sys) disable iff (!arst_n)
      (master_tx_sync && tx_on_high_reg == 6'h3F) |=> (transmit_driver_enable == 6'h3F);
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("driver not enabled");

  property p_tx_off;
    @(posedge clk_sys) disable iff (!arst_n)
      (tx_on_high_reg == 6'h00) |=> (tx_line_oe_n == 6'h3F);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx pins not floated");

  property p_rx_on;
    @(posedge clk_sys) disable iff (!arst_n)
      (host_req.wr && host_req.addr == COG_OFS_RX_ON) |=> ##1 (receiver_enable_bit == $past(wr_bits, 2));
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receiver enable mismatch");

  property p_rx_off;
    @(posedge clk_sys) disable iff (!arst_n)
      (rx_on_high_reg == 6'h00) |=> (rx_line_oe_n == 6'h3F);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx pins not floated");

  property p_mask;
    @(posedge clk_sys) disable iff (!arst_n)
      (irq_master_enable_low_reg == 6'h00) |=> irq_out_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt reached pin");

  property p_irq;
    @(posedge clk_sys) disable iff (!arst_n)
      // A same-edge enable write may legally mask the event
      ((|(set_mask & irq_master_enable_low_reg)) && !(host_req.wr && host_req.addr == COG_OFS_IRQ_EN))
        |-> s_irq_raise ##1 !irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_sticky;
    @(posedge clk_sys) disable iff (!arst_n)
      (|keep_mask) |=> ((irq_status_reg & $past(keep_mask)) == $past(keep_mask));
  endproperty
  a_sticky: assert property (p_sticky) else $error("status cleared without read");

  property p_resv;
    @(posedge clk_sys) disable iff (!arst_n)
      host_req.rd |=> (host_rdata[7:6] == 2'b00);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits nonzero");

  property p_status_set;
    @(posedge clk_sys) disable iff (!arst_n)
      (|set_mask) |=> ((irq_status_reg & $past(set_mask)) == $past(set_mask));
  endproperty
  a_status_set: assert property (p_status_set) else $error("enabled event not recorded");

  property p_status_clr;
    @(posedge clk_sys) disable iff (!arst_n)
      (|clr_mask) |=> ((irq_status_reg & $past(clr_mask)) == 6'h00);
  endproperty
  a_status_clr: assert property (p_status_clr) else $error("status not cleared by read");

  property p_rd_status;
    @(posedge clk_sys) disable iff (!arst_n)
      (host_req.rd && host_req.addr == COG_OFS_IRQ_ST) |=> (host_rdata == {2'b00, $past(irq_status_reg)});
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status readback mismatch");

  property p_tx_wr;
    @(posedge clk_sys) disable iff (!arst_n)
      (host_req.wr && host_req.addr == COG_OFS_TX_ON) |=> (tx_on_high_reg == $past(wr_bits));
  endproperty
  a_tx_wr: assert property (p_tx_wr) else $error("tx on write not taken");

  property p_en_wr;
    @(posedge clk_sys) disable iff (!arst_n)
      (host_req.wr && host_req.addr == COG_OFS_IRQ_EN) |=> (irq_master_enable_low_reg == $past(wr_bits));
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("master enable write not taken");

  property p_rx_pins;
    @(posedge clk_sys) disable iff (!arst_n)
      (rx_on_high_reg != 6'h00) |=> (rx_line_oe_n == ~$past(rx_on_high_reg));
  endproperty
  a_rx_pins: assert property (p_rx_pins) else $error("rx pins disagree with receiver bits");

  property p_tx_pins;
    @(posedge clk_sys) disable iff (!arst_n)
      (transmit_driver_enable != 6'h00) |-> (tx_line_oe_n == ~transmit_driver_enable);
  endproperty
  a_tx_pins: assert property (p_tx_pins) else $error("tx pins disagree with driver enable");
endmodule : cog_top

// ===== include/cog_pkg.sv
// Functional notes
// - Tx-on bit set in 0x80 enables that upper channel's line driver.
// - Tx-on bit clear shuts driver off, both transmit pins high-impedance.
// - Driver enable is master transmit pin AND register bit.
// - Rx-on bit set in 0x88 enables that upper channel's receiver.
// - Rx-on bit clear switches receiver off, receive pins high-impedance.
// - Cleared master enable in 0x60 blocks that channel from the interrupt pin.
// - Set master enable passes source-enabled channel interrupts to the interrupt pin.
// - Channel status bit at 0x61 sticks until source status register is read.
package cog_pkg;
  localparam int COG_NCH = 6;
  localparam logic [7:0] COG_OFS_IRQ_EN = 8'h60;
  localparam logic [7:0] COG_OFS_IRQ_ST = 8'h61;
  localparam logic [7:0] COG_OFS_TX_ON = 8'h80;
  localparam logic [7:0] COG_OFS_RX_ON = 8'h88;
  localparam logic [5:0] COG_RST_IRQ_EN = 6'h00;
  localparam logic [5:0] COG_RST_TX_ON = 6'h00;
  localparam logic [5:0] COG_RST_RX_ON = 6'h00;
  localparam logic [7:0] COG_RD_UNMAPPED = 8'h00;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cog_req_t;

  typedef struct packed {
    logic [5:0] irq_req;
    logic [5:0] src_en;
    logic [5:0] src_read;
  } cog_chan_t;
endpackage : cog_pkg

// ===== test/channel_onoff_irq_gating_test.sv
`timescale 1ns/100ps
module channel_onoff_irq_gating_test;
  import cog_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic pin = 1'b0;
  cog_req_t host_req;
  cog_chan_t chan = '0;
  logic [7:0] host_rdata;
  logic [7:0] rd_v;
  logic [5:0] tde, txoe, rxoe, rxen;
  logic irq_n;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  initial forever #20 clk_sys = ~clk_sys;
  cog_host i_host (.clk_sys(clk_sys), .host_req(host_req), .host_rdata(host_rdata));
  cog_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .host_req(host_req), .host_rdata(host_rdata),
    .master_tx_en_pin(pin), .chan(chan), .transmit_driver_enable(tde), .tx_line_oe_n(txoe),
    .rx_line_oe_n(rxoe), .receiver_enable_bit(rxen), .irq_out_n(irq_n));
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, rd_v);
    chk("rdata", e, rd_v);
  endtask : rchk
  // Event pulse, pin sampled two cycles after the taking edge
  task automatic ev(input logic [5:0] m, input logic [5:0] en, input logic [7:0] e);
    chan.irq_req = m;
    chan.src_en = en;
    @(negedge clk_sys);
    chan.irq_req = '0;
    repeat (2) @(negedge clk_sys);
    chk("irq_n", e, {7'h00, irq_n});
  endtask : ev
  // Hang guard, far above the some fifty cycles needed
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    arst_n = 1'b1;
    chk("txoe", 8'h3F, {2'h0, txoe});
    chk("irq_n", 8'h01, {7'h00, irq_n});
    rchk(COG_OFS_TX_ON, 8'h00);
    rchk(8'h40, COG_RD_UNMAPPED);
    i_host.wr(COG_OFS_TX_ON, 8'hFF);
    rchk(COG_OFS_TX_ON, 8'h3F);
    repeat (4) @(negedge clk_sys);
    chk("tde", 8'h00, {2'h0, tde});
    pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("tde", 8'h3F, {2'h0, tde});
    chk("txoe", 8'h00, {2'h0, txoe});
    i_host.wr(COG_OFS_TX_ON, 8'h15);
    repeat (2) @(negedge clk_sys);
    chk("txoe", 8'h2A, {2'h0, txoe});
    i_host.wr(COG_OFS_RX_ON, 8'hC9);
    repeat (2) @(negedge clk_sys);
    chk("rxen", 8'h09, {2'h0, rxen});
    chk("rxoe", 8'h36, {2'h0, rxoe});
    rchk(COG_OFS_RX_ON, 8'h09);
    i_host.wr(COG_OFS_IRQ_EN, 8'h44);
    rchk(COG_OFS_IRQ_EN, 8'h04);
    ev(6'h08, 6'h08, 8'h01);
    rchk(COG_OFS_IRQ_ST, 8'h08);
    ev(6'h02, 6'h00, 8'h01);
    ev(6'h04, 6'h04, 8'h00);
    chan.src_read = 6'h04;
    @(negedge clk_sys);
    chan.src_read = '0;
    repeat (2) @(negedge clk_sys);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("tde", 8'h00, {2'h0, tde});
    summarize();
  end
endmodule : channel_onoff_irq_gating_test

// ===== test/cog_host.sv
`timescale 1ns/100ps
module cog_host (
  // Clock
  input wire logic clk_sys,
  // Register port
  output cog_pkg::cog_req_t host_req,
  input wire logic [7:0] host_rdata
);
  import cog_pkg::*;
  initial host_req = '0;
  // Strobes change only at the falling edge, held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys);
    host_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    host_req <= '0;
    d = host_rdata;
  endtask : rd
endmodule : cog_host
